// ==== rtl/hpsp_top.v ====
// Contract
// - gates off unless retention held low
// - debounce retention for about 10 ms
// - override low turns all three outputs on
// - override disables all protections
// - override ignores lockouts except standby supply
// - override forces power-ok low, releases others; code also forces delayed power-ok low
// - power-ok outputs open-drain, after power-on reset
// - power-ok when enabled slot delivers power
// - delayed power-ok 164 ms after power-ok
// - one open-drain system power-ok after reset
// - system power-ok low only for bad slot
// - unused or disabled slots leave it high
// - enables active high, undriven reads asserted
// - requests taken only after supplies valid
// - attention released by enable falling edge
// - main trip re-armed by high-low-high enable
`timescale 1ns/1ps
`default_nettype none
`include "hpsp_regs.vh"
module hpsp_top #(
  parameter DEB_CYC = `HPSP_DEB_CYC,
  parameter DLY_CYC = `HPSP_DLY_CYC,
  parameter POR_CYC = `HPSP_POR_CYC
)(
  input wire clk_i,
  input wire rst_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire supplies_ok_i,
  input wire stby_supply_ok_i,
  input wire [1:0] card_retention_n_i,
  input wire [1:0] override_n_i,
  input wire [1:0] main_enable_i,
  input wire [1:0] main_enable_oe_i,
  input wire [1:0] standby_rail_enable_i,
  input wire [1:0] standby_rail_enable_oe_i,
  input wire [1:0] main_trip_i,
  input wire [1:0] high_ok_i,
  input wire [1:0] low_ok_i,
  input wire [1:0] stby_ok_i,
  output reg [1:0] high_rail_gate_o,
  output reg [1:0] low_rail_gate_o,
  output reg [1:0] standby_output_o,
  output reg [1:0] slot_power_ok_n_o,
  output reg [1:0] slot_power_ok_n_oe_o,
  output reg [1:0] delayed_power_ok_n_o,
  output reg [1:0] delayed_power_ok_n_oe_o,
  output reg system_power_ok_o,
  output reg system_power_ok_oe_o,
  output reg [1:0] attention_n_oe_o
);
  reg [15:0] por_cnt;
  reg por_done;
  wire [1:0] s_high;
  wire [1:0] s_low;
  wire [1:0] s_stby;
  wire [1:0] s_pg;
  wire [1:0] s_dpg;
  wire [1:0] s_bad;
  wire [1:0] s_trip;
  wire [1:0] s_attn;
  wire [1:0] s_ret;
  // undriven enable line reads asserted: pull-up modelled from the enable's output enable
  wire [1:0] me = main_enable_i | ~main_enable_oe_i;
  wire [1:0] se = standby_rail_enable_i | ~standby_rail_enable_oe_i;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : slot
      hpsp_slot #(
        .DEB_CYC(DEB_CYC),
        .DLY_CYC(DLY_CYC)
      ) u_slot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .por_done_i(por_done),
        .supplies_ok_i(supplies_ok_i),
        .stby_supply_ok_i(stby_supply_ok_i),
        .card_retention_n_i(card_retention_n_i[g]),
        .override_n_i(override_n_i[g]),
        .main_enable_i(me[g]),
        .standby_rail_enable_i(se[g]),
        .main_trip_i(main_trip_i[g]),
        .high_ok_i(high_ok_i[g]),
        .low_ok_i(low_ok_i[g]),
        .stby_ok_i(stby_ok_i[g]),
        .high_rail_gate_o(s_high[g]),
        .low_rail_gate_o(s_low[g]),
        .standby_output_o(s_stby[g]),
        .power_ok_o(s_pg[g]),
        .delayed_ok_o(s_dpg[g]),
        .sys_bad_o(s_bad[g]),
        .tripped_o(s_trip[g]),
        .attention_o(s_attn[g]),
        .retained_o(s_ret[g])
      );
    end
  endgenerate
  function [31:0] slot_word;
    input i;
    begin
      slot_word = 32'h00000000;
      slot_word[`HPSP_ST_RET] = s_ret[i];
      slot_word[`HPSP_ST_OVR] = ~override_n_i[i];
      slot_word[`HPSP_ST_PG] = s_pg[i];
      slot_word[`HPSP_ST_DPG] = s_dpg[i];
      slot_word[`HPSP_ST_TRIP] = s_trip[i];
      slot_word[`HPSP_ST_ATTN] = s_attn[i];
      slot_word[`HPSP_ST_HIGH] = s_high[i];
      slot_word[`HPSP_ST_LOW] = s_low[i];
      slot_word[`HPSP_ST_STBY] = s_stby[i];
    end
  endfunction
  reg sw_por;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      por_cnt <= 16'h0000;
      por_done <= 1'b0;
    end
    else if (!por_done)
    begin
      if (por_cnt == POR_CYC[15:0] - 16'h0001)
        por_done <= 1'b1;
      else
        por_cnt <= por_cnt + 16'h0001;
    end
  end
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      high_rail_gate_o <= 2'h0;
      low_rail_gate_o <= 2'h0;
      standby_output_o <= 2'h0;
      slot_power_ok_n_o <= 2'h0;
      slot_power_ok_n_oe_o <= 2'h0;
      delayed_power_ok_n_o <= 2'h0;
      delayed_power_ok_n_oe_o <= 2'h0;
      system_power_ok_o <= 1'b0;
      system_power_ok_oe_o <= 1'b0;
      attention_n_oe_o <= 2'h0;
    end
    else
    begin
      high_rail_gate_o <= s_high;
      low_rail_gate_o <= s_low;
      standby_output_o <= s_stby;
      slot_power_ok_n_oe_o <= s_pg;
      delayed_power_ok_n_oe_o <= s_dpg;
      // any override releases the shared system line; a slot's override releases its own attention
      system_power_ok_oe_o <= por_done & (|s_bad) &
        (&override_n_i);
      attention_n_oe_o <= s_attn;
    end
  end
  // wishbone slave: one wait state, ack one cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      sw_por <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      sw_por <= por_done;
      if (wb_cyc_i & wb_stb_i & ~wb_ack_o)
      begin
        case (wb_adr_i[3:0])
          `HPSP_ADR_CTRL: wb_dat_o <= {31'h00000000, sw_por};
          `HPSP_ADR_STAT: wb_dat_o <= {28'h0000000, s_bad, s_trip};
          `HPSP_ADR_SLOTA: wb_dat_o <= slot_word(1'b0);
          `HPSP_ADR_SLOTB: wb_dat_o <= slot_word(1'b1);
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/hpsp_regs.vh ====
`ifndef HPSP_REGS_VH
`define HPSP_REGS_VH
// register offsets (byte addresses)
`define HPSP_ADR_CTRL 4'h0
`define HPSP_ADR_STAT 4'h4
`define HPSP_ADR_SLOTA 4'h8
`define HPSP_ADR_SLOTB 4'hC
// control fields
`define HPSP_CTRL_POR_DONE 0
`define HPSP_CTRL_RESET 32'h00000000
// slot status fields
`define HPSP_ST_RET 0
`define HPSP_ST_OVR 1
`define HPSP_ST_PG 2
`define HPSP_ST_DPG 3
`define HPSP_ST_TRIP 4
`define HPSP_ST_ATTN 5
`define HPSP_ST_HIGH 6
`define HPSP_ST_LOW 7
`define HPSP_ST_STBY 8
// timing
`define HPSP_CLK_HZ 20000000
`define HPSP_DEB_MS 10
`define HPSP_DLY_MS 164
`define HPSP_POR_US 160
`define HPSP_DEB_CYC (`HPSP_CLK_HZ / 1000 * `HPSP_DEB_MS)
`define HPSP_DLY_CYC (`HPSP_CLK_HZ / 1000 * `HPSP_DLY_MS)
`define HPSP_POR_CYC (`HPSP_CLK_HZ / 1000000 * `HPSP_POR_US)
`endif

// ==== rtl/hpsp_slot.v ====
`timescale 1ns/1ps
`default_nettype none
`include "hpsp_regs.vh"
module hpsp_slot #(
  parameter DEB_CYC = `HPSP_DEB_CYC,
  parameter DLY_CYC = `HPSP_DLY_CYC,
  parameter CW = 23
)(
  input wire clk_i,
  input wire rst_i,
  input wire por_done_i,
  input wire supplies_ok_i,
  input wire stby_supply_ok_i,
  input wire card_retention_n_i,
  input wire override_n_i,
  input wire main_enable_i,
  input wire standby_rail_enable_i,
  input wire main_trip_i,
  input wire high_ok_i,
  input wire low_ok_i,
  input wire stby_ok_i,
  output reg high_rail_gate_o,
  output reg low_rail_gate_o,
  output reg standby_output_o,
  output reg power_ok_o,
  output reg delayed_ok_o,
  output reg sys_bad_o,
  output reg tripped_o,
  output reg attention_o,
  output reg retained_o
);
  reg [CW-1:0] deb_cnt;
  reg [CW-1:0] dly_cnt;
  reg ret_raw;
  reg me_q;
  reg se_q;
  reg [1:0] rearm;
  wire ovr = ~override_n_i;
  wire me_fall = me_q & ~main_enable_i;
  wire se_fall = se_q & ~standby_rail_enable_i;
  wire next_high;
  wire next_low;
  wire next_stby;
  wire next_pg;
  // without override, gates need a debounced retention, live supplies and no latched trip
  assign next_high = ovr ? stby_supply_ok_i :
    (retained_o & supplies_ok_i & main_enable_i & ~tripped_o);
  assign next_low = next_high;
  assign next_stby = ovr ? stby_supply_ok_i :
    (retained_o & stby_supply_ok_i & standby_rail_enable_i);
  assign next_pg = ovr | (retained_o & main_enable_i & ~tripped_o &
    high_ok_i & low_ok_i & stby_ok_i & standby_rail_enable_i);
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      deb_cnt <= {CW{1'b0}};
      dly_cnt <= {CW{1'b0}};
      ret_raw <= 1'b0;
      retained_o <= 1'b0;
      me_q <= 1'b1;
      se_q <= 1'b1;
      rearm <= 2'b00;
      tripped_o <= 1'b0;
      attention_o <= 1'b0;
      high_rail_gate_o <= 1'b0;
      low_rail_gate_o <= 1'b0;
      standby_output_o <= 1'b0;
      power_ok_o <= 1'b0;
      delayed_ok_o <= 1'b0;
      sys_bad_o <= 1'b0;
    end
    else
    begin
      me_q <= main_enable_i;
      se_q <= standby_rail_enable_i;
      // debounce: accept a level only after it holds for DEB_CYC cycles
      ret_raw <= ~card_retention_n_i;
      if (ret_raw == retained_o)
        deb_cnt <= {CW{1'b0}};
      else if (deb_cnt == DEB_CYC[CW-1:0] - 1'b1)
      begin
        retained_o <= ret_raw;
        deb_cnt <= {CW{1'b0}};
      end
      else
        deb_cnt <= deb_cnt + 1'b1;
      // fault trip ignored under override; re-arm needs high-low-high
      if (main_trip_i & ~ovr & high_rail_gate_o & ~tripped_o)
      begin
        tripped_o <= 1'b1;
        rearm <= 2'b00;
      end
      else if (tripped_o)
      begin
        if (rearm == 2'b00 && main_enable_i)
          rearm <= 2'b01;
        else if (rearm == 2'b01 && !main_enable_i)
          rearm <= 2'b10;
        else if (rearm == 2'b10 && main_enable_i)
          tripped_o <= 1'b0;
      end
      // attention set by a trip, released by an enable falling edge or by override
      if (main_trip_i & ~ovr & high_rail_gate_o)
        attention_o <= 1'b1;
      else if (ovr | me_fall | se_fall)
        attention_o <= 1'b0;
      high_rail_gate_o <= por_done_i & next_high;
      low_rail_gate_o <= por_done_i & next_low;
      standby_output_o <= por_done_i & next_stby;
      power_ok_o <= por_done_i & next_pg;
      if (!(por_done_i & next_pg))
      begin
        dly_cnt <= {CW{1'b0}};
        delayed_ok_o <= 1'b0;
      end
      else if (ovr)
        delayed_ok_o <= 1'b1;
      else if (power_ok_o & ~delayed_ok_o)
      begin
        if (dly_cnt == DLY_CYC[CW-1:0] - 1'b1)
          delayed_ok_o <= 1'b1;
        else
          dly_cnt <= dly_cnt + 1'b1;
      end
      sys_bad_o <= retained_o & (main_enable_i | standby_rail_enable_i) &
        ~ovr & ((main_enable_i & ~(high_ok_i & low_ok_i)) |
        (standby_rail_enable_i & ~stby_ok_i));
    end
  end
endmodule
`default_nettype wire

// ==== verif/hpsp_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module hpsp_chk #(
  parameter POR_CYC = 8,
  parameter DLY_CYC = 50,
  parameter DEB_CYC = 20
)(
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire stby_supply_ok_i,
  input wire [1:0] card_retention_n_i,
  input wire [1:0] override_n_i,
  input wire [1:0] main_enable_i,
  input wire [1:0] main_enable_oe_i,
  input wire [1:0] standby_rail_enable_i,
  input wire [1:0] standby_rail_enable_oe_i,
  input wire [1:0] high_rail_gate_o,
  input wire [1:0] low_rail_gate_o,
  input wire [1:0] standby_output_o,
  input wire [1:0] slot_power_ok_n_oe_o,
  input wire [1:0] delayed_power_ok_n_oe_o,
  input wire system_power_ok_oe_o,
  input wire [1:0] attention_n_oe_o
);
  int por_cnt;
  int pg_cnt;
  int rel_cnt [2];
  wire [1:0] held;
  wire [1:0] req;
  // a slot stays in use until its retention has been released for longer
  // than the debounce time
  assign held = {rel_cnt[1] < DEB_CYC + 4, rel_cnt[0] < DEB_CYC + 4};
  // a released enable reads asserted through its pull-up
  assign req = (~main_enable_oe_i | main_enable_i | ~standby_rail_enable_oe_i
    | standby_rail_enable_i) & override_n_i & held;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  always @(posedge clk_i)
  begin
    if (rst_i)
      por_cnt <= 0;
    else if (por_cnt < POR_CYC)
      por_cnt <= por_cnt + 1;
    if (rst_i || !slot_power_ok_n_oe_o[0])
      pg_cnt <= 0;
    else
      pg_cnt <= pg_cnt + 1;
    for (int s = 0; s < 2; s++)
      if (rst_i)
        rel_cnt[s] <= DEB_CYC + 4;
      else if (!card_retention_n_i[s])
        rel_cnt[s] <= 0;
      else if (rel_cnt[s] < DEB_CYC + 4)
        rel_cnt[s] <= rel_cnt[s] + 1;
  end
  por_quiet_a: assert property (por_cnt < POR_CYC |->
    (slot_power_ok_n_oe_o | delayed_power_ok_n_oe_o | high_rail_gate_o
    | low_rail_gate_o | standby_output_o) == 2'b00)
    else $error("output active in power-on reset");
  gate_hold_a: assert property ((high_rail_gate_o
    & ~$past(high_rail_gate_o) & card_retention_n_i & override_n_i) == 2'b00)
    else $error("gate rose without retention");
  override_on_a: assert property ((stby_supply_ok_i && !override_n_i[1]
    && por_cnt == POR_CYC)[*6] |-> high_rail_gate_o[1]
    && low_rail_gate_o[1] && standby_output_o[1])
    else $error("override left slot off");
  override_pg_a: assert property ((stby_supply_ok_i && !override_n_i[1]
    && por_cnt == POR_CYC)[*6] |-> slot_power_ok_n_oe_o[1]
    && delayed_power_ok_n_oe_o[1] && !attention_n_oe_o[1])
    else $error("override status wrong");
  dly_delay_a: assert property ($rose(delayed_power_ok_n_oe_o[0])
    && override_n_i[0] |-> pg_cnt >= DLY_CYC - 2 && pg_cnt <= DLY_CYC + 2)
    else $error("delayed power-ok timing wrong");
  sys_release_a: assert property ((req == 2'b00)[*6] |->
    !system_power_ok_oe_o)
    else $error("system power-ok pulled low");
  stby_lock_a: assert property ((!stby_supply_ok_i)[*6] |->
    standby_output_o == 2'b00)
    else $error("standby output on without supply");
  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
endmodule
`default_nettype wire

// ==== verif/hpsp_ctl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module hpsp_ctl_model (
  input wire logic clk_i,
  output logic [1:0] card_retention_n_o = 2'b11,
  output logic [1:0] main_enable_oe_o = 2'b00,
  output logic [1:0] standby_rail_enable_oe_o = 2'b00
);
  task set_ret(input int s, input logic v);
    @(posedge clk_i);
    card_retention_n_o[s] <= v;
  endtask
  // open-drain: driving means pulling the enable low
  task set_en(input int s, input logic m, input logic a);
    @(posedge clk_i);
    main_enable_oe_o[s] <= !m;
    standby_rail_enable_oe_o[s] <= !a;
  endtask
endmodule
`default_nettype wire

// ==== verif/hotplug_slot_pwr_status_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hpsp_regs.vh"
module hotplug_slot_pwr_status_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] adr = 32'h0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic sup = 1'b1;
  logic ssup = 1'b1;
  logic [1:0] ovr_n = 2'b11;
  logic [1:0] trip = 2'b00;
  logic [1:0] bad = 2'b00;
  logic [31:0] d;
  wire [31:0] dat;
  wire ack;
  wire sys, sysd;
  wire [1:0] ret_n, me_oe, se_oe, hg, lg, sg, pg, dpg, attn, pgd, dpgd;
  int error_cnt = 0;
  int num_checks = 0;
  initial forever #25 clk_i = ~clk_i;
  hpsp_ctl_model u_hpsp_ctl_model (.clk_i(clk_i), .card_retention_n_o(ret_n),
    .main_enable_oe_o(me_oe), .standby_rail_enable_oe_o(se_oe));
  hpsp_top #(.DEB_CYC(20), .DLY_CYC(50), .POR_CYC(8)) u_hpsp_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(32'hFFFFFFFF),
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_dat_o(dat), .wb_ack_o(ack), .supplies_ok_i(sup),
    .stby_supply_ok_i(ssup), .card_retention_n_i(ret_n),
    .override_n_i(ovr_n), .main_enable_i(~me_oe), .main_enable_oe_i(me_oe),
    .standby_rail_enable_i(~se_oe), .standby_rail_enable_oe_i(se_oe),
    .main_trip_i(trip), .high_ok_i(hg & ~bad), .low_ok_i(lg), .stby_ok_i(sg),
    .high_rail_gate_o(hg), .low_rail_gate_o(lg), .standby_output_o(sg),
    .slot_power_ok_n_o(pgd), .slot_power_ok_n_oe_o(pg),
    .delayed_power_ok_n_o(dpgd), .delayed_power_ok_n_oe_o(dpg),
    .system_power_ok_o(sysd), .system_power_ok_oe_o(sys),
    .attention_n_oe_o(attn));
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task give_verdict;
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wcyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task wb(input logic w, input logic [31:0] a);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= a;
    we <= w;
    cyc <= 1'b1;
    @(posedge clk_i);
    while (ack !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        error_cnt++;
        give_verdict;
      end
      @(posedge clk_i);
    end
    d = dat;
    cyc <= 1'b0;
  endtask
  initial
  begin
    wcyc(5000);
    error_cnt++;
    give_verdict;
  end
  initial
  begin
    wcyc(2);
    rst_i <= 1'b0;
    wb(0, `HPSP_ADR_CTRL);
    chk(d, 32'h0);
    wcyc(10);
    wb(1, `HPSP_ADR_CTRL);
    wb(0, `HPSP_ADR_CTRL);
    chk(d, 32'h1);
    wb(0, 32'h2);
    chk(d, 32'h0);
    chk({hg, lg, sg, pg, sys}, 9'h0);
    chk({pgd, dpgd, sysd}, 5'h0);
    u_hpsp_ctl_model.set_ret(0, 1'b0);
    wcyc(16);
    chk(hg, 2'b00);
    wcyc(12);
    chk({hg, lg, sg}, 6'h15);
    wcyc(8);
    chk({pg, dpg}, 4'h4);
    wcyc(56);
    chk(dpg, 2'b01);
    wb(0, `HPSP_ADR_SLOTA);
    chk(d, 32'h1CD);
    trip <= 2'b01;
    wcyc(1);
    trip <= 2'b00;
    wcyc(6);
    chk({hg, attn}, 4'h1);
    wb(0, `HPSP_ADR_STAT);
    chk(d, 32'h5);
    u_hpsp_ctl_model.set_en(0, 1'b0, 1'b1);
    wcyc(6);
    chk(attn, 2'b00);
    u_hpsp_ctl_model.set_en(0, 1'b1, 1'b1);
    wcyc(8);
    chk(hg, 2'b01);
    bad <= 2'b01;
    wcyc(6);
    chk({sys, pg}, 3'h4);
    u_hpsp_ctl_model.set_en(0, 1'b0, 1'b0);
    wcyc(6);
    chk({sys, hg, sg}, 5'h0);
    bad <= 2'b00;
    ovr_n <= 2'b01;
    sup <= 1'b0;
    trip <= 2'b10;
    wcyc(8);
    chk({hg, lg, sg, pg, dpg}, 10'h2AA);
    wb(0, `HPSP_ADR_SLOTB);
    chk(d, 32'h1CE);
    trip <= 2'b00;
    ssup <= 1'b0;
    wcyc(8);
    chk({hg, sg}, 4'h0);
    ssup <= 1'b1;
    ovr_n <= 2'b11;
    u_hpsp_ctl_model.set_en(0, 1'b1, 1'b1);
    wcyc(10);
    chk(hg, 2'b00);
    sup <= 1'b1;
    wcyc(10);
    chk(hg, 2'b01);
    give_verdict;
  end
endmodule
bind hpsp_top hpsp_chk #(.POR_CYC(POR_CYC), .DLY_CYC(DLY_CYC),
  .DEB_CYC(DEB_CYC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .stby_supply_ok_i(stby_supply_ok_i),
  .card_retention_n_i(card_retention_n_i), .override_n_i(override_n_i),
  .main_enable_i(main_enable_i), .main_enable_oe_i(main_enable_oe_i),
  .standby_rail_enable_i(standby_rail_enable_i),
  .standby_rail_enable_oe_i(standby_rail_enable_oe_i),
  .high_rail_gate_o(high_rail_gate_o), .low_rail_gate_o(low_rail_gate_o),
  .standby_output_o(standby_output_o),
  .slot_power_ok_n_oe_o(slot_power_ok_n_oe_o),
  .delayed_power_ok_n_oe_o(delayed_power_ok_n_oe_o),
  .system_power_ok_oe_o(system_power_ok_oe_o),
  .attention_n_oe_o(attention_n_oe_o));
`default_nettype wire
